/* dec_error_memory.sv */
`timescale 1ns/10ps
`default_nettype none

package dec_pkg;
  // error code ranges, held in the top nibble of the code
  localparam logic [3:0] RANGE_GENERAL = 4'h1;
  localparam logic [3:0] RANGE_OVERCURRENT = 4'h2;
  localparam logic [3:0] RANGE_VOLTAGE = 4'h3;
  localparam logic [3:0] RANGE_TEMPERATURE = 4'h4;
  localparam logic [3:0] RANGE_HARDWARE = 4'h5;
  localparam logic [3:0] RANGE_SOFTWARE = 4'h6;
  localparam logic [3:0] RANGE_INTERFACE = 4'h7;
  localparam logic [3:0] RANGE_FIELDBUS = 4'h8;
  localparam logic [3:0] RANGE_MOVEMENT = 4'hA;
  localparam logic [3:0] RANGE_COMMUNICATION = 4'hB;
  // parameter access error codes
  localparam logic [15:0] CODE_OUT_OF_RANGE = {RANGE_GENERAL, 12'h100};
  localparam logic [15:0] CODE_NO_INDEX = {RANGE_GENERAL, 12'h101};
  localparam logic [15:0] CODE_NO_SUBINDEX = {RANGE_GENERAL, 12'h102};
  localparam logic [15:0] CODE_READ_ONLY = {RANGE_GENERAL, 12'h103};
  localparam logic [15:0] CODE_NO_AUTH = {RANGE_GENERAL, 12'h104};
  localparam logic [15:0] CODE_POWER_ACTIVE = {RANGE_GENERAL, 12'h106};
  localparam logic [15:0] CODE_CHANNEL_BLOCKED = {RANGE_GENERAL, 12'h107};
  localparam logic [15:0] CODE_CONFIG_CHECK = {RANGE_GENERAL, 12'h10B};
  localparam logic [15:0] CODE_RESTART_NEEDED = {RANGE_GENERAL, 12'h10E};
  localparam logic [15:0] CODE_VARIANT_UNSUPPORTED = {RANGE_GENERAL, 12'h10F};
  localparam logic [15:0] CODE_UNAVAILABLE = {RANGE_GENERAL, 12'h110};
  localparam logic [15:0] CODE_NONE = 16'h0000;
  // error classes
  localparam logic [2:0] CLASS_0 = 3'h0;
  localparam logic [2:0] CLASS_1 = 3'h1;
  localparam logic [2:0] CLASS_2 = 3'h2;
  localparam logic [2:0] CLASS_3 = 3'h3;
  localparam logic [2:0] CLASS_4 = 3'h4;
  // latched signal flag positions
  localparam int FLAG_CONFIG_BIT = 30;
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
  // access channels
  localparam logic CHAN_FIELDBUS = 1'b0;
  localparam logic CHAN_TOOL = 1'b1;
  // error memory
  localparam int MEM_DEPTH = 10;
  localparam int PTR_W = 4;
  localparam logic [PTR_W-1:0] PTR_OLDEST = 4'h0;
  localparam logic [PTR_W-1:0] COUNT_FULL = 4'hA;
  // operating response states
  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_QUICK_STOP = 4'b0010,
    ST_FAULT_DECEL = 4'b0100,
    ST_FAULT = 4'b1000
  } dec_state_t;
endpackage

module dec_error_memory (
  input wire logic clock,
  input wire logic rst,
  input wire logic push,
  input wire logic [15:0] push_code,
  input wire logic [2:0] push_class,
  input wire logic [15:0] push_info,
  input wire logic read_code,
  input wire logic rewind,
  input wire logic clear,
  output logic [15:0] error_entry_code,
  output logic [2:0] buf_class,
  output logic [15:0] error_additional_info,
  output logic [3:0] entry_count,
  output logic clear_busy
);

  logic [15:0] code_reg [dec_pkg::MEM_DEPTH];
  logic [2:0] class_reg [dec_pkg::MEM_DEPTH];
  logic [15:0] info_reg [dec_pkg::MEM_DEPTH];
  logic [3:0] count_reg;
  logic [3:0] rd_ptr_reg;
  logic full;
  logic have_entry;

  assign full = (count_reg == dec_pkg::COUNT_FULL);
  assign have_entry = (rd_ptr_reg < count_reg);

  // --------------------------------------------------------------
  // entry storage
  // --------------------------------------------------------------
  // when full the oldest entry falls out at position 0 and the rest shift down
  genvar i;
  generate
    for (i = 0; i < dec_pkg::MEM_DEPTH; i++)
    begin : g_entry
      // the top position takes the new entry, so it never shifts from beyond the array
      localparam int NEXT_POS = (i == dec_pkg::MEM_DEPTH - 1) ? i : i + 1;
      always_ff @(posedge clock)
      begin
        if (rst || clear)
        begin
          code_reg[i] <= dec_pkg::CODE_NONE;
          class_reg[i] <= dec_pkg::CLASS_0;
          info_reg[i] <= 16'h0000;
        end
        else if (push && full)
        begin
          if (i == dec_pkg::MEM_DEPTH - 1)
          begin
            code_reg[i] <= push_code; // [RULE17]
            class_reg[i] <= push_class;
            info_reg[i] <= push_info;
          end
          else
          begin
            code_reg[i] <= code_reg[NEXT_POS]; // [RULE17]
            class_reg[i] <= class_reg[NEXT_POS];
            info_reg[i] <= info_reg[NEXT_POS];
          end
        end
        else if (push && count_reg == 4'(i))
        begin
          code_reg[i] <= push_code; // [RULE22]
          class_reg[i] <= push_class;
          info_reg[i] <= push_info;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock)
  begin
    if (rst || clear)
      count_reg <= 4'h0; // [RULE20]
    else if (push && !full)
      count_reg <= count_reg + 4'h1;
  end

  // --------------------------------------------------------------
  // read pointer and intermediate buffer
  // --------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst || clear || rewind)
      rd_ptr_reg <= dec_pkg::PTR_OLDEST; // [RULE19]
    else if (read_code && have_entry)
      rd_ptr_reg <= rd_ptr_reg + 4'h1; // [RULE18]
  end

  // reading past the newest entry returns zeroes
  always_ff @(posedge clock)
  begin
    if (rst || clear)
    begin
      error_entry_code <= dec_pkg::CODE_NONE;
      buf_class <= dec_pkg::CLASS_0;
      error_additional_info <= 16'h0000;
    end
    else if (read_code)
    begin
      error_entry_code <= have_entry ? code_reg[rd_ptr_reg] : dec_pkg::CODE_NONE; // [RULE18]
      buf_class <= have_entry ? class_reg[rd_ptr_reg] : dec_pkg::CLASS_0;
      error_additional_info <= have_entry ? info_reg[rd_ptr_reg] : 16'h0000;
    end
  end

  // busy for the single cycle the wipe takes, then reads back 0
  always_ff @(posedge clock)
  begin
    if (rst)
      clear_busy <= 1'b0;
    else
      clear_busy <= clear; // [RULE20]
  end

  assign entry_count = count_reg;

endmodule

`default_nettype wire

/* dec_classifier.sv */
// How it works
// [RULE1] every detected fault produces a message with a code and a class; only one event is logged per cycle and coinciding ones are dropped
// [RULE2] the code's top hex digit names the range, general to communication
// [RULE3] class 0 is only recorded; no state change, movement continues
// [RULE4] class 1 takes the quick stop transition, power stage stays enabled
// [RULE5] class 2 quick stops then disables power at standstill via fault transitions
// [RULE6] classes 3 and 4 disable the power stage at once via fault entry
// [RULE7] fault reset clears classes 0 to 3; class 4 needs a power cycle
// [RULE8] write outside permissible range is rejected with class 0 code 1100
// [RULE9] missing index gives 1101, missing subindex gives 1102, both class 0
// [RULE10] write to read-only parameter refused with class 0 code 1103
// [RULE11] expert parameter write without authorization denied, class 0 code 1104
// [RULE12] command forbidden while power stage enabled refused, class 0 code 1106
// [RULE13] access while the other channel holds access blocked, class 0 code 1107
// [RULE14] consistency failure: class 3 code 110B, flag bit 30, address as info
// [RULE15] restart-pending parameter change gives class 0 code 110E, tool only
// [RULE16] unsupported variant function gives 110F, unavailable function gives 1110
// [RULE17] error memory keeps ten entries, oldest first, newest last
// [RULE18] reading the code copies the entry to a buffer and advances the pointer
// [RULE19] pointer rewind returns the read pointer to the oldest entry at once
// [RULE20] memory clear deletes all entries; done when a read returns 0
// [RULE21] with several errors active the highest class response applies
// [RULE22] each entry stores a 16-bit code with the range in the top nibble
`timescale 1ns/10ps
`default_nettype none

module dec_classifier (
  input wire logic clock,
  input wire logic rst,
  // parameter access request, checked in one cycle
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic acc_channel,
  input wire logic acc_index_exists,
  input wire logic acc_subindex_exists,
  input wire logic acc_in_range,
  input wire logic acc_read_only,
  input wire logic acc_expert_param,
  input wire logic acc_expert_auth,
  input wire logic acc_needs_power_off,
  input wire logic acc_needs_restart,
  input wire logic acc_variant_unsupported,
  input wire logic acc_unavailable,
  input wire logic [1:0] channel_hold,
  // consistency check and other monitoring functions
  input wire logic consistency_fail,
  input wire logic [15:0] consistency_addr,
  input wire logic mon_valid,
  input wire logic [15:0] mon_code,
  input wire logic [2:0] mon_class,
  // operating conditions
  input wire logic power_stage_enabled,
  input wire logic motor_standstill,
  input wire logic fault_reset,
  // error memory management
  input wire logic error_code_read,
  input wire logic error_pointer_rewind,
  input wire logic error_memory_clear,
  // access answer
  output logic acc_done,
  output logic acc_accepted,
  output logic [15:0] acc_error_code,
  output logic [2:0] acc_error_class,
  output logic tool_notify,
  // response
  output logic quick_stop_transition,
  output logic fault_entry_transition,
  output logic fault_reaction_done_transition,
  output logic quick_stop_active,
  output logic power_stage_disable,
  output logic [2:0] active_class,
  output logic [3:0] last_error_range,
  output logic [31:0] latched_signal_flags,
  // error memory
  output logic [15:0] error_entry_code,
  output logic [2:0] error_entry_class,
  output logic [15:0] error_additional_info,
  output logic [3:0] error_entry_count,
  output logic error_memory_clear_busy
);

  dec_pkg::dec_state_t state_reg;
  dec_pkg::dec_state_t state_next;
  logic [15:0] chk_code;
  logic chk_fail;
  logic chk_report;
  logic other_holds;
  logic ev_valid;
  logic [15:0] ev_code;
  logic [2:0] ev_class;
  logic [15:0] ev_info;
  logic [2:0] worst_next;
  logic reset_ok;
  logic log_push;

  // --------------------------------------------------------------
  // parameter access checks
  // --------------------------------------------------------------
  // the order below fixes which code wins when a request breaks several checks
  assign other_holds = channel_hold[~acc_channel] && !channel_hold[acc_channel];

  always_comb
  begin
    chk_code = dec_pkg::CODE_NONE;
    chk_fail = 1'b0;
    chk_report = 1'b0;
    if (other_holds)
    begin
      chk_code = dec_pkg::CODE_CHANNEL_BLOCKED; // [RULE13]
      chk_fail = 1'b1;
    end
    else if (!acc_index_exists)
    begin
      chk_code = dec_pkg::CODE_NO_INDEX; // [RULE9]
      chk_fail = 1'b1;
    end
    else if (!acc_subindex_exists)
    begin
      chk_code = dec_pkg::CODE_NO_SUBINDEX; // [RULE9]
      chk_fail = 1'b1;
    end
    else if (acc_unavailable)
    begin
      chk_code = dec_pkg::CODE_UNAVAILABLE; // [RULE16]
      chk_fail = 1'b1;
    end
    else if (acc_variant_unsupported)
    begin
      chk_code = dec_pkg::CODE_VARIANT_UNSUPPORTED; // [RULE16]
      chk_fail = 1'b1;
    end
    else if (acc_write && acc_read_only)
    begin
      chk_code = dec_pkg::CODE_READ_ONLY; // [RULE10]
      chk_fail = 1'b1;
    end
    else if (acc_write && acc_expert_param && !acc_expert_auth)
    begin
      chk_code = dec_pkg::CODE_NO_AUTH; // [RULE11]
      chk_fail = 1'b1;
    end
    else if (acc_needs_power_off && power_stage_enabled)
    begin
      chk_code = dec_pkg::CODE_POWER_ACTIVE; // [RULE12]
      chk_fail = 1'b1;
    end
    else if (acc_write && !acc_in_range)
    begin
      chk_code = dec_pkg::CODE_OUT_OF_RANGE; // [RULE8]
      chk_fail = 1'b1;
    end
    else if (acc_write && acc_needs_restart && acc_channel == dec_pkg::CHAN_TOOL)
    begin
      // the write itself is taken; the fieldbus side never sees this code
      chk_code = dec_pkg::CODE_RESTART_NEEDED; // [RULE15]
      chk_report = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      acc_done <= 1'b0;
      acc_accepted <= 1'b0;
      acc_error_code <= dec_pkg::CODE_NONE;
      acc_error_class <= dec_pkg::CLASS_0;
      tool_notify <= 1'b0;
    end
    else
    begin
      acc_done <= acc_valid;
      acc_accepted <= acc_valid && !chk_fail;
      acc_error_code <= acc_valid ? chk_code : dec_pkg::CODE_NONE;
      acc_error_class <= dec_pkg::CLASS_0; // [RULE3]
      tool_notify <= acc_valid && chk_report; // [RULE15]
    end
  end

  // --------------------------------------------------------------
  // event selection for logging
  // --------------------------------------------------------------
  // one entry per cycle: a class 3 consistency fault beats a monitor
  // message, which beats an access error in the same cycle
  always_comb
  begin
    ev_valid = 1'b1;
    ev_code = dec_pkg::CODE_NONE;
    ev_class = dec_pkg::CLASS_0;
    ev_info = 16'h0000;
    if (consistency_fail)
    begin
      ev_code = dec_pkg::CODE_CONFIG_CHECK; // [RULE14]
      ev_class = dec_pkg::CLASS_3;
      ev_info = consistency_addr; // [RULE14]
    end
    else if (mon_valid)
    begin
      ev_code = mon_code; // [RULE1]
      ev_class = mon_class;
    end
    else if (acc_valid && (chk_fail || chk_report))
      ev_code = chk_code; // [RULE1]
    else
      ev_valid = 1'b0;
  end

  assign log_push = ev_valid;

  // --------------------------------------------------------------
  // active class tracking
  // --------------------------------------------------------------
  assign reset_ok = fault_reset && (active_class != dec_pkg::CLASS_4);

  always_comb
  begin
    worst_next = reset_ok ? dec_pkg::CLASS_0 : active_class; // [RULE7]
    // a new error in the reset cycle survives the reset
    if (ev_valid && ev_class > worst_next)
      worst_next = ev_class; // [RULE21]
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      active_class <= dec_pkg::CLASS_0;
    else
      active_class <= worst_next;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      last_error_range <= 4'h0;
    else if (ev_valid)
      last_error_range <= ev_code[15:12]; // [RULE2]
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      latched_signal_flags <= dec_pkg::FLAGS_RESET;
    else if (consistency_fail)
      latched_signal_flags[dec_pkg::FLAG_CONFIG_BIT] <= 1'b1; // [RULE14]
    else if (reset_ok)
      latched_signal_flags <= dec_pkg::FLAGS_RESET; // [RULE7]
  end

  // --------------------------------------------------------------
  // stop response state machine
  // --------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      dec_pkg::ST_RUN,
      dec_pkg::ST_QUICK_STOP:
      begin
        if (worst_next >= dec_pkg::CLASS_3)
          state_next = dec_pkg::ST_FAULT; // [RULE6]
        else if (worst_next == dec_pkg::CLASS_2)
          state_next = dec_pkg::ST_FAULT_DECEL; // [RULE5]
        else if (worst_next == dec_pkg::CLASS_1)
          state_next = dec_pkg::ST_QUICK_STOP; // [RULE4]
        else if (state_reg == dec_pkg::ST_QUICK_STOP && reset_ok)
          state_next = dec_pkg::ST_RUN; // [RULE7]
      end
      dec_pkg::ST_FAULT_DECEL:
      begin
        if (worst_next >= dec_pkg::CLASS_3 || motor_standstill)
          state_next = dec_pkg::ST_FAULT; // [RULE5]
      end
      dec_pkg::ST_FAULT:
      begin
        if (worst_next == dec_pkg::CLASS_0)
          state_next = dec_pkg::ST_RUN; // [RULE7]
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      state_reg <= dec_pkg::ST_RUN;
    else
      state_reg <= state_next;
  end

  // class 0 never moves the state, so none of these fire for it
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      quick_stop_transition <= 1'b0;
      fault_entry_transition <= 1'b0;
      fault_reaction_done_transition <= 1'b0;
      quick_stop_active <= 1'b0;
      power_stage_disable <= 1'b0;
    end
    else
    begin
      quick_stop_transition <= state_next == dec_pkg::ST_QUICK_STOP && state_reg == dec_pkg::ST_RUN; // [RULE4]
      fault_entry_transition <= (state_next == dec_pkg::ST_FAULT_DECEL || state_next == dec_pkg::ST_FAULT) &&
                                (state_reg == dec_pkg::ST_RUN || state_reg == dec_pkg::ST_QUICK_STOP); // [RULE6]
      fault_reaction_done_transition <= state_next == dec_pkg::ST_FAULT && state_reg != dec_pkg::ST_FAULT; // [RULE5]
      quick_stop_active <= state_next == dec_pkg::ST_QUICK_STOP || state_next == dec_pkg::ST_FAULT_DECEL; // [RULE4]
      power_stage_disable <= state_next == dec_pkg::ST_FAULT; // [RULE6]
    end
  end

  // --------------------------------------------------------------
  // error memory
  // --------------------------------------------------------------
  dec_error_memory u_memory (
    .clock(clock),
    .rst(rst),
    .push(log_push),
    .push_code(ev_code),
    .push_class(ev_class),
    .push_info(ev_info),
    .read_code(error_code_read),
    .rewind(error_pointer_rewind),
    .clear(error_memory_clear),
    .error_entry_code(error_entry_code),
    .buf_class(error_entry_class),
    .error_additional_info(error_additional_info),
    .entry_count(error_entry_count),
    .clear_busy(error_memory_clear_busy)
  );

endmodule

`default_nettype wire

/* dec_classifier_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module dec_classifier_assertions (
  input wire logic clock,
  input wire logic rst,
  input wire logic acc_valid,
  input wire logic acc_channel,
  input wire logic [1:0] channel_hold,
  input wire logic consistency_fail,
  input wire logic mon_valid,
  input wire logic [2:0] mon_class,
  input wire logic motor_standstill,
  input wire logic fault_reset,
  input wire logic error_memory_clear,
  input wire logic acc_done,
  input wire logic [15:0] acc_error_code,
  input wire logic quick_stop_transition,
  input wire logic fault_entry_transition,
  input wire logic quick_stop_active,
  input wire logic power_stage_disable,
  input wire logic [2:0] active_class,
  input wire logic [31:0] latched_signal_flags,
  input wire logic [3:0] error_entry_count
);
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  a_done_follows: assert property (acc_valid |=> acc_done)
    else $error("access got no answer");
  a_other_blocked: assert property (acc_valid && channel_hold[!acc_channel] && !channel_hold[acc_channel]
    |=> acc_error_code == 16'h1107) else $error("blocked channel code wrong");
  a_clear_empties: assert property (error_memory_clear |=> error_entry_count == 4'h0)
    else $error("clear left entries");
  a_consist_flag: assert property (consistency_fail |=> latched_signal_flags[30] && power_stage_disable)
    else $error("consistency fault response wrong");
  a_class1_stop: assert property (mon_valid && mon_class == 3'h1 && active_class == 3'h0 && !consistency_fail
    |=> quick_stop_transition && quick_stop_active && !power_stage_disable) else $error("class 1 response wrong");
  a_class0_quiet: assert property (mon_valid && mon_class == 3'h0 && active_class == 3'h0 && !consistency_fail
    |=> active_class == 3'h0 && !quick_stop_transition && !fault_entry_transition) else $error("class 0 moved");
  a_class4_sticky: assert property (active_class == 3'h4 |=> active_class == 3'h4)
    else $error("class 4 cleared without power cycle");
  a_standstill_off: assert property (quick_stop_active && active_class == 3'h2 && motor_standstill && !fault_reset
    |=> power_stage_disable && !quick_stop_active) else $error("no disable at standstill");
  c_blocked: cover property (acc_valid && channel_hold == 2'h2 && !acc_channel);
  c_class2: cover property (quick_stop_active && active_class == 3'h2 && motor_standstill);
  c_clear: cover property (error_memory_clear && error_entry_count != 4'h0);
endmodule
bind dec_classifier dec_classifier_assertions chk (.clock, .rst, .acc_valid, .acc_channel, .channel_hold,
  .consistency_fail, .mon_valid, .mon_class, .motor_standstill, .fault_reset, .error_memory_clear, .acc_done,
  .acc_error_code, .quick_stop_transition, .fault_entry_transition, .quick_stop_active, .power_stage_disable,
  .active_class, .latched_signal_flags, .error_entry_count);
`default_nettype wire

/* dec_param_master.sv */
`timescale 1ns/10ps
`default_nettype none
module dec_param_master (
  input wire logic clock,
  output logic acc_valid,
  output logic acc_write,
  output logic acc_channel,
  output logic [9:0] acc_flags,
  output logic [1:0] channel_hold,
  output logic [3:0] strobes
);
  initial
  begin
    {acc_valid, acc_write, acc_channel, acc_flags, channel_hold, strobes} = 19'h0;
  end
  // write and flag qualifiers show inverted data once released, so a stale value never passes; channel and hold keep theirs
  task automatic access(input logic wr, input logic ch, input logic [1:0] h, input logic [9:0] f);
    @(negedge clock);
    {acc_valid, acc_write, acc_channel, channel_hold, acc_flags} = {1'b1, wr, ch, h, f};
    @(negedge clock);
    {acc_valid, acc_write, acc_flags} = {1'b0, ~wr, ~f};
  endtask
  // strobes: fault reset, code read, rewind, clear
  task automatic strobe(input logic [3:0] s);
    @(negedge clock);
    strobes = s;
    @(negedge clock);
    strobes = 4'h0;
  endtask
endmodule
`default_nettype wire

/* dec_classifier_test.sv */
`timescale 1ns/10ps
`default_nettype none
module dec_classifier_test;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic mon_valid = 1'b0, consistency_fail = 1'b0, power_stage_enabled = 1'b0, motor_standstill = 1'b0;
  logic [15:0] mon_code = 16'h0000, consistency_addr = 16'h0000;
  logic [2:0] mon_class = 3'h0;
  logic acc_valid, acc_write, acc_channel, acc_done, acc_accepted, tool_notify, error_memory_clear_busy;
  logic quick_stop_transition, fault_entry_transition, fault_reaction_done_transition;
  logic quick_stop_active, power_stage_disable;
  logic [9:0] fl;
  logic [1:0] channel_hold;
  logic [3:0] sb, last_error_range, error_entry_count;
  logic [15:0] acc_error_code, error_entry_code, error_additional_info;
  logic [2:0] acc_error_class, active_class, error_entry_class;
  logic [31:0] latched_signal_flags;
  logic [15:0] lg[$];
  logic [30:0] t;
  int error_cnt = 0;
  int checked = 0;
  always #2 clock = ~clock;
  dec_param_master m (.clock, .acc_valid, .acc_write, .acc_channel, .acc_flags(fl), .channel_hold, .strobes(sb));
  dec_classifier dut (.clock, .rst, .acc_valid, .acc_write, .acc_channel, .acc_index_exists(fl[9]),
    .acc_subindex_exists(fl[8]), .acc_in_range(fl[7]), .acc_read_only(fl[6]), .acc_expert_param(fl[5]),
    .acc_expert_auth(fl[4]), .acc_needs_power_off(fl[3]), .acc_needs_restart(fl[2]),
    .acc_variant_unsupported(fl[1]), .acc_unavailable(fl[0]), .channel_hold, .consistency_fail,
    .consistency_addr, .mon_valid, .mon_code, .mon_class, .power_stage_enabled, .motor_standstill,
    .fault_reset(sb[3]), .error_code_read(sb[2]), .error_pointer_rewind(sb[1]), .error_memory_clear(sb[0]),
    .acc_done, .acc_accepted, .acc_error_code, .acc_error_class, .tool_notify, .quick_stop_transition,
    .fault_entry_transition, .fault_reaction_done_transition, .quick_stop_active, .power_stage_disable,
    .active_class, .last_error_range, .latched_signal_flags, .error_entry_code, .error_entry_class,
    .error_additional_info, .error_entry_count, .error_memory_clear_busy);
  // ----------
  // helpers
  // ----------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic ev(input logic v, input logic [2:0] c, input logic cf, input logic [15:0] a);
    @(negedge clock);
    {mon_valid, mon_class, mon_code, consistency_fail, consistency_addr} = {v, c, 13'h1400, c, cf, a};
    @(negedge clock);
    {mon_valid, consistency_fail} = 2'h0;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----------
  // scenarios
  // ----------
  task automatic t_access;
    for (int i = 0; i < 12; i++)
    begin
      // only the last request runs with the power stage off
      power_stage_enabled = (i != 11);
      case (i)
        0: t = {4'h0, 10'h180, 1'b0, 16'h1101};
        1: t = {4'h0, 10'h280, 1'b0, 16'h1102};
        2: t = {4'h0, 10'h381, 1'b0, 16'h1110};
        3: t = {4'h0, 10'h382, 1'b0, 16'h110F};
        4: t = {4'h8, 10'h3C0, 1'b0, 16'h1103};
        5: t = {4'h8, 10'h3A0, 1'b0, 16'h1104};
        6: t = {4'h8, 10'h388, 1'b0, 16'h1106};
        7: t = {4'h8, 10'h300, 1'b0, 16'h1100};
        8: t = {4'hA, 10'h380, 1'b0, 16'h1107};
        9: t = {4'hC, 10'h384, 1'b1, 16'h110E};
        10: t = {4'h8, 10'h384, 1'b1, 16'h0000};
        default: t = {4'hE, 10'h3B8, 1'b1, 16'h0000};
      endcase
      m.access(t[30], t[29], t[28:27], t[26:17]);
      chk(32'(acc_done), 32'h1);
      chk(32'(acc_error_code), 32'(t[15:0]));
      chk({acc_accepted, acc_error_class}, {t[16], 3'h0});
      chk(32'(tool_notify), 32'(t[15:0] == 16'h110E));
      if (t[15:0] != 16'h0000)
        lg.push_back(t[15:0]);
    end
    chk(32'(error_entry_count), 32'hA);
    $display("test access done");
  endtask
  task automatic t_memory;
    m.strobe(4'h2);
    for (int i = 0; i < 11; i++)
    begin
      m.strobe(4'h4);
      chk({error_entry_class, error_entry_code}, (i < 10) ? {3'h0, lg[i]} : 19'h0);
    end
    ev(1'b1, 3'h0, 1'b0, 16'h0000);
    chk({active_class, quick_stop_transition, fault_entry_transition}, 5'h0);
    chk(32'(last_error_range), 32'hA);
    m.strobe(4'h2);
    m.strobe(4'h4);
    chk(32'(error_entry_code), 32'(lg[1]));
    m.strobe(4'h1);
    chk({error_entry_count, error_memory_clear_busy}, 5'h01);
    m.strobe(4'h4);
    chk(32'(error_entry_code), 32'h0);
    $display("test memory done");
  endtask
  task automatic t_class12;
    ev(1'b1, 3'h1, 1'b0, 16'h0000);
    chk({quick_stop_transition, quick_stop_active, power_stage_disable}, 3'h6);
    m.strobe(4'h8);
    chk({quick_stop_active, active_class}, 4'h0);
    ev(1'b1, 3'h2, 1'b0, 16'h0000);
    chk({fault_entry_transition, quick_stop_active, power_stage_disable}, 3'h6);
    ev(1'b1, 3'h1, 1'b0, 16'h0000);
    chk(32'(active_class), 32'h2);
    motor_standstill = 1'b1;
    @(negedge clock);
    chk({fault_reaction_done_transition, power_stage_disable, quick_stop_active}, 3'h6);
    motor_standstill = 1'b0;
    m.strobe(4'h8);
    chk(32'(power_stage_disable), 32'h0);
    $display("test class12 done");
  endtask
  task automatic t_class34;
    // earlier monitor events are still stored; start empty so the first read is the consistency entry
    m.strobe(4'h1);
    ev(1'b0, 3'h0, 1'b1, 16'h3C0A);
    chk({fault_entry_transition, fault_reaction_done_transition, power_stage_disable}, 3'h7);
    chk(latched_signal_flags, 32'h4000_0000);
    m.strobe(4'h2);
    m.strobe(4'h4);
    chk({error_entry_class, error_entry_code, error_additional_info}, {3'h3, 16'h110B, 16'h3C0A});
    m.strobe(4'h8);
    chk({latched_signal_flags[30], power_stage_disable}, 2'h0);
    ev(1'b1, 3'h4, 1'b0, 16'h0000);
    m.strobe(4'h8);
    chk({active_class, power_stage_disable}, 4'h9);
    rst = 1'b1;
    repeat (16) @(negedge clock);
    rst = 1'b0;
    chk(32'(active_class), 32'h0);
    $display("test class34 done");
  endtask
  initial
  begin
    repeat (16) @(negedge clock);
    rst = 1'b0;
    t_access();
    t_memory();
    t_class12();
    t_class34();
    final_report();
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    final_report();
  end
endmodule
`default_nettype wire
